/* File: swire_pkg.sv */
// timing constants and the command type for the single-wire slot link
// assumes a 200 MHz sys_clk; the _NS figures are in nanoseconds, the _CYC figures in sys_clk cycles
package swire_pkg;
  localparam int CLK_PERIOD_NS     = 5;
  // master-side figures
  localparam int RESET_LOW_NS      = 480000;
  localparam int RESET_HIGH_NS     = 480000;
  localparam int PRESENCE_SMP_NS   = 70000;
  localparam int WRITE_ZERO_LOW_NS = 60000;
  localparam int WRITE_ONE_LOW_NS  = 5000;
  localparam int READ_LOW_NS       = 5000;
  localparam int READ_SAMPLE_NS    = 13000;
  localparam int SLOT_NS           = 70000;
  // device-side figures
  localparam int WRITE_ONE_MAX_NS  = 15000;
  localparam int DEV_SAMPLE_NS     = 30000;
  localparam int DEV_HOLD_NS       = 30000;
  localparam int PRESENCE_WAIT_NS  = 30000;
  localparam int PRESENCE_LOW_NS   = 120000;
  localparam int RESET_DETECT_NS   = 400000;
  localparam int IDLE_LOW_NS       = 120000;
  // cycle counts
  localparam int RESET_LOW_CYC     = RESET_LOW_NS / CLK_PERIOD_NS;
  localparam int RESET_HIGH_CYC    = RESET_HIGH_NS / CLK_PERIOD_NS;
  localparam int PRESENCE_SMP_CYC  = PRESENCE_SMP_NS / CLK_PERIOD_NS;
  localparam int WRITE_ZERO_CYC    = WRITE_ZERO_LOW_NS / CLK_PERIOD_NS;
  localparam int WRITE_ONE_CYC     = WRITE_ONE_LOW_NS / CLK_PERIOD_NS;
  localparam int READ_LOW_CYC      = READ_LOW_NS / CLK_PERIOD_NS;
  localparam int READ_SAMPLE_CYC   = READ_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int SLOT_CYC          = SLOT_NS / CLK_PERIOD_NS;
  localparam int WRITE_ONE_MAX_CYC = WRITE_ONE_MAX_NS / CLK_PERIOD_NS;
  localparam int DEV_SAMPLE_CYC    = DEV_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int DEV_HOLD_CYC      = DEV_HOLD_NS / CLK_PERIOD_NS;
  localparam int PRESENCE_WAIT_CYC = PRESENCE_WAIT_NS / CLK_PERIOD_NS;
  localparam int PRESENCE_LOW_CYC  = PRESENCE_LOW_NS / CLK_PERIOD_NS;
  localparam int RESET_DETECT_CYC  = (RESET_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CMD_BITS          = 8;
  localparam int CNT_W             = 18;

  typedef enum logic [1:0] {CMD_RESET, CMD_WRITE, CMD_READ} cmd_t;
endpackage

/* File: swire_if.sv */
// wired-AND single wire shared by the bus master end and the device end
// assumes an external pullup: the line is high unless an end pulls low
`timescale 1ns/100ps
interface swire_if;
  logic masterLineOut;
  logic masterLineOe_n;
  logic deviceLineOut;
  logic deviceLineOe_n;
  logic line;

  // open drain resolution with pullup
  assign line = !((!masterLineOe_n && !masterLineOut) || (!deviceLineOe_n && !deviceLineOut));

  modport master (input line, output masterLineOut, output masterLineOe_n);
  modport device (input line, output deviceLineOut, output deviceLineOe_n);
endinterface

/* File: line_sync.sv */
// two flip-flop synchroniser with change markers for the shared line
// assumes the line idles high, so the flops reset to one
`timescale 1ns/100ps
module line_sync
(
  input  wire logic sys_clk,  // system clock
  input  wire logic reset_n,  // async reset, active low
  input  wire logic lineIn,   // raw line level
  output logic      lineLvl,  // synchronised level
  output logic      fallEdge, // one-cycle pulse on high to low
  output logic      riseEdge  // one-cycle pulse on low to high
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= lineIn;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign lineLvl  = sync_q;
  assign fallEdge = last_q & ~sync_q;
  assign riseEdge = ~last_q & sync_q;
endmodule

/* File: swire_device.sv */
// device end of the single-wire link: presence pulse and bit slots
// assumes the master originates every slot; line resolved by swire_if
`timescale 1ns/100ps
module swire_device
  import swire_pkg::*;
#(
  parameter int SAMPLE_CYC = DEV_SAMPLE_CYC,   // write sample point
  parameter int HOLD_CYC   = DEV_HOLD_CYC,     // read-zero pulldown length
  parameter int WAIT_CYC   = PRESENCE_WAIT_CYC,
  parameter int PRES_CYC   = PRESENCE_LOW_CYC,
  parameter int RST_CYC    = RESET_DETECT_CYC
)
(
  input  wire logic sys_clk,    // system clock
  input  wire logic reset_n,    // async reset, active low
  swire_if.device   bus,        // shared line
  input  wire logic txBit,      // bit to return in next read slot
  input  wire logic readMode,   // 1: slots are read slots
  output logic      rxValid,    // one-cycle pulse, rxBit valid
  output logic      rxBit,      // received write bit
  output logic      txTaken,    // one-cycle pulse, txBit consumed
  output logic      cmdValid,   // one-cycle pulse, cmdByte valid
  output logic [swire_pkg::CMD_BITS-1:0] cmdByte, // first byte after presence
  output logic      linkReady,  // presence sent, link initialised
  output logic      busReset    // one-cycle pulse on detected reset
);
  import swire_pkg::*;

  initial
  begin
    if (SAMPLE_CYC <= WRITE_ONE_MAX_CYC || RST_CYC >= (1 << CNT_W) || HOLD_CYC < 1)
      $error("swire_device: timing parameters out of range");
  end

  typedef enum logic [2:0] {IDLE, SLOT, REC, RST_LOW, PRES_WAIT, PRES_LOW} dstate_t;

  typedef struct packed {
    dstate_t             st;
    logic [CNT_W-1:0]    cnt;
    logic [CNT_W-1:0]    lowCnt;
    logic                pull;
    logic                zeroReply;
    logic                readSlot;
    logic                ready;
    logic                cmdDone;
    logic [3:0]          bitIdx;
    logic [CMD_BITS-1:0] shift;
    logic                rxValid;
    logic                rxBit;
    logic                txTaken;
    logic                cmdValid;
    logic [CMD_BITS-1:0] cmdByte;
    logic                busReset;
  } dev_t;

  dev_t s_q;
  dev_t s_d;

  logic lineLvl;
  logic fallEdge;
  logic riseEdge;

  // thresholds are modelled by the synchronised level
  line_sync u_sync
  (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .lineIn   (bus.line),
    .lineLvl  (lineLvl),
    .fallEdge (fallEdge),
    .riseEdge (riseEdge)
  );

  function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
    return (v == {CNT_W{1'b1}}) ? v : CNT_W'(v + 1'b1);
  endfunction

  always_comb
  begin
    s_d          = s_q;
    s_d.rxValid  = 1'b0;
    s_d.txTaken  = 1'b0;
    s_d.cmdValid = 1'b0;
    s_d.busReset = 1'b0;
    s_d.cnt      = inc(s_q.cnt);
    s_d.lowCnt   = lineLvl ? '0 : inc(s_q.lowCnt);

    unique case (s_q.st)
      IDLE:
      begin
        // timing generator starts on falling edge
        if (fallEdge)
        begin
          s_d.st        = SLOT;
          s_d.cnt       = '0;
          s_d.readSlot  = readMode;
          s_d.zeroReply = readMode & ~txBit;
          // zero reply starts pulling inside read low window
          s_d.pull      = readMode & ~txBit;
          s_d.txTaken   = readMode;
        end
      end
      SLOT:
      begin
        // a one reply leaves pull clear throughout
        if (s_q.zeroReply && s_q.cnt == CNT_W'(HOLD_CYC - 1))
          s_d.pull = 1'b0;
        // one bit per slot, sampled at the write point
        if (!s_q.readSlot && s_q.cnt == CNT_W'(SAMPLE_CYC - 1))
        begin
          s_d.rxValid = 1'b1;
          s_d.rxBit   = lineLvl;
          // command bits shift in lsb first
          if (s_q.ready && !s_q.cmdDone)
          begin
            s_d.shift  = {lineLvl, s_q.shift[CMD_BITS-1:1]};
            s_d.bitIdx = s_q.bitIdx + 4'h1;
            if (s_q.bitIdx == 4'(CMD_BITS - 1))
            begin
              s_d.cmdDone  = 1'b1;
              s_d.cmdValid = 1'b1;
              s_d.cmdByte  = {lineLvl, s_q.shift[CMD_BITS-1:1]};
            end
          end
        end
        // wait for high line before recovery
        if (s_q.cnt >= CNT_W'(SAMPLE_CYC) && !s_d.pull && lineLvl)
          s_d.st = REC;
      end
      REC:
      begin
        s_d.st = IDLE;
        if (fallEdge)
        begin
          s_d.st        = SLOT;
          s_d.cnt       = '0;
          s_d.readSlot  = readMode;
          s_d.zeroReply = readMode & ~txBit;
          s_d.pull      = readMode & ~txBit;
          s_d.txTaken   = readMode;
        end
      end
      RST_LOW:
      begin
        // presence waits for the line to return high
        if (lineLvl)
        begin
          s_d.st  = PRES_WAIT;
          s_d.cnt = '0;
        end
      end
      PRES_WAIT:
      begin
        if (s_q.cnt == CNT_W'(WAIT_CYC - 1))
        begin
          // presence is the only self-started pulldown
          s_d.st   = PRES_LOW;
          s_d.cnt  = '0;
          s_d.pull = 1'b1;
        end
      end
      PRES_LOW:
      begin
        if (s_q.cnt == CNT_W'(PRES_CYC - 1))
        begin
          s_d.st    = IDLE;
          s_d.pull  = 1'b0;
          s_d.ready = 1'b1;
        end
      end
      default:
        s_d.st = IDLE;
    endcase

    // overlong low aborts anything and counts as reset
    if (!s_q.pull && s_q.lowCnt == CNT_W'(RST_CYC - 1) && s_q.st != RST_LOW)
    begin
      s_d.st        = RST_LOW;
      s_d.pull      = 1'b0;
      s_d.zeroReply = 1'b0;
      s_d.ready     = 1'b0;
      s_d.cmdDone   = 1'b0;
      s_d.bitIdx    = '0;
      s_d.busReset  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '{st: IDLE, default: '0};
    else
      s_q <= s_d;
  end

  assign bus.deviceLineOut  = 1'b0;
  assign bus.deviceLineOe_n = ~s_q.pull;
  assign rxValid   = s_q.rxValid;
  assign rxBit     = s_q.rxBit;
  assign txTaken   = s_q.txTaken;
  assign cmdValid  = s_q.cmdValid;
  assign cmdByte   = s_q.cmdByte;
  assign linkReady = s_q.ready;
  assign busReset  = s_q.busReset;
endmodule

/* File: swire_master.sv */
// bus master end: reset/presence, write and read slots on request
// assumes one request at a time, taken while reqReady is high
`timescale 1ns/100ps
module swire_master
  import swire_pkg::*;
#(
  parameter int RST_LOW_CYC  = RESET_LOW_CYC,
  parameter int RST_HIGH_CYC = RESET_HIGH_CYC,
  parameter int SLOT_LEN_CYC = SLOT_CYC,
  parameter int PRES_SMP_CYC = PRESENCE_SMP_CYC, // presence sample point
  parameter int W0_LOW_CYC   = WRITE_ZERO_CYC    // write-zero low length
)
(
  input  wire logic sys_clk,   // system clock
  input  wire logic reset_n,   // async reset, active low
  swire_if.master   bus,       // shared line
  input  wire logic reqValid,  // request strobe
  input  wire swire_pkg::cmd_t reqCmd, // reset, write or read
  input  wire logic reqBit,    // bit to write
  output logic      reqReady,  // idle, may take a request
  output logic      doneValid, // one-cycle pulse, result valid
  output logic      doneBit    // read bit or presence seen (1)
);
  import swire_pkg::*;

  initial
  begin
    if (RST_LOW_CYC >= (1 << CNT_W) || RST_HIGH_CYC <= PRES_SMP_CYC
        || SLOT_LEN_CYC <= W0_LOW_CYC || W0_LOW_CYC <= WRITE_ONE_CYC)
      $error("swire_master: timing parameters out of range");
  end

  typedef enum logic [1:0] {M_IDLE, M_RST_LOW, M_RST_HIGH, M_SLOT} mstate_t;

  typedef struct packed {
    mstate_t          st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lowLen;
    logic             isRead;
    logic             pull;
    logic             res;
    logic             doneValid;
  } mst_t;

  mst_t s_q;
  mst_t s_d;
  logic lineLvl;

  line_sync u_sync
  (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .lineIn   (bus.line),
    .lineLvl  (lineLvl),
    .fallEdge (),
    .riseEdge ()
  );

  always_comb
  begin
    s_d           = s_q;
    s_d.doneValid = 1'b0;
    s_d.cnt       = CNT_W'(s_q.cnt + 1'b1);
    unique case (s_q.st)
      M_IDLE:
      begin
        s_d.cnt = '0;
        if (reqValid)
        begin
          s_d.pull   = 1'b1;
          s_d.isRead = (reqCmd == CMD_READ);
          s_d.st     = (reqCmd == CMD_RESET) ? M_RST_LOW : M_SLOT;
          s_d.lowLen = (reqCmd == CMD_READ) ? CNT_W'(READ_LOW_CYC)
                     : (reqBit ? CNT_W'(WRITE_ONE_CYC) : CNT_W'(W0_LOW_CYC));
        end
      end
      M_RST_LOW:
      begin
        // reset low fixed, well under 960 us
        if (s_q.cnt == CNT_W'(RST_LOW_CYC - 1))
        begin
          s_d.pull = 1'b0;
          s_d.st   = M_RST_HIGH;
          s_d.cnt  = '0;
        end
      end
      M_RST_HIGH:
      begin
        if (s_q.cnt == CNT_W'(PRES_SMP_CYC - 1))
          s_d.res = ~lineLvl;
        // full reset high time before anything else
        if (s_q.cnt == CNT_W'(RST_HIGH_CYC - 1))
        begin
          s_d.st        = M_IDLE;
          s_d.doneValid = 1'b1;
        end
      end
      M_SLOT:
      begin
        if (s_q.cnt == s_q.lowLen - 1'b1)
          s_d.pull = 1'b0;
        if (s_q.isRead && s_q.cnt == CNT_W'(READ_SAMPLE_CYC - 1))
          s_d.res = lineLvl;
        if (s_q.cnt == CNT_W'(SLOT_LEN_CYC - 1))
        begin
          s_d.st        = M_IDLE;
          s_d.doneValid = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '{st: M_IDLE, default: '0};
    else
      s_q <= s_d;
  end

  assign bus.masterLineOut  = 1'b0;
  assign bus.masterLineOe_n = ~s_q.pull;
  assign reqReady  = (s_q.st == M_IDLE);
  assign doneValid = s_q.doneValid;
  assign doneBit   = s_q.res;
endmodule

/* File: swire_chk.sv */
// concurrent checks on the shared wire between the master and device ends
// assumes plain hookup to the swire_if signals, one sys_clk domain
`timescale 1ns/100ps
module swire_chk
  import swire_pkg::*;
#(
  parameter int RST_LOW_CYC  = RESET_LOW_CYC,
  parameter int RST_HIGH_CYC = RESET_HIGH_CYC,
  parameter int SLOT_LEN_CYC = SLOT_CYC,
  parameter int WAIT_CYC     = PRESENCE_WAIT_CYC,
  parameter int PRES_CYC     = PRESENCE_LOW_CYC,
  parameter int HOLD_CYC     = DEV_HOLD_CYC,
  parameter int W0_CYC       = WRITE_ZERO_CYC
)
(
  input wire logic sys_clk,        // system clock
  input wire logic reset_n,        // async reset, active low
  input wire logic masterLineOut,  // master data, open drain
  input wire logic masterLineOe_n, // master pulls low
  input wire logic deviceLineOut,  // device data, open drain
  input wire logic deviceLineOe_n, // device pulls low
  input wire logic line            // resolved wire
);
  localparam int PRES_LO = WAIT_CYC;
  localparam int PRES_HI = WAIT_CYC + 8;
  typedef struct packed {
    logic [CNT_W-1:0] mLow;
    logic [CNT_W-1:0] mHigh;
    logic [CNT_W-1:0] dLow;
    logic [CNT_W-1:0] lineHigh;
    logic             lastRst;
  } chk_state_t;
  chk_state_t st_q;
  chk_state_t st_d;
  // ----------------------------------------
  // run-length counters
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.mLow = masterLineOe_n ? '0 : st_q.mLow + 1'b1;
    st_d.dLow = deviceLineOe_n ? '0 : st_q.dLow + 1'b1;
    st_d.mHigh = !masterLineOe_n ? '0 : st_q.mHigh + CNT_W'(st_q.mHigh != '1);
    st_d.lineHigh = !line ? '0 : st_q.lineHigh + CNT_W'(st_q.lineHigh != '1);
    if (masterLineOe_n && st_q.mLow != '0)
      st_d.lastRst = st_q.mLow >= RST_LOW_CYC - 1 && st_q.mLow <= RST_LOW_CYC + 1;
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '{mLow: '0, mHigh: '1, dLow: '0, lineHigh: '1, lastRst: 1'b0};
    else
      st_q <= st_d;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  master_drain_a:
    assert property (masterLineOut == 1'b0) else $error("master drove the wire high");
  device_drain_a:
    assert property (deviceLineOut == 1'b0) else $error("device drove the wire high");
  wire_and_a:
    assert property (line == (masterLineOe_n && deviceLineOe_n)) else $error("bad wire level");
  pull_start_a:
    assert property ($fell(deviceLineOe_n) |-> !$past(line) || st_q.lineHigh >= WAIT_CYC)
      else $error("device pulled an idle wire");
  rise_quiet_a:
    assert property ($rose(line) |-> deviceLineOe_n [*8]) else $error("device pulled after rise");
  master_low_len_a:
    assert property ($rose(masterLineOe_n) |-> st_q.mLow inside
      {[WRITE_ONE_CYC-1:WRITE_ONE_CYC+1], [W0_CYC-1:W0_CYC+1],
       [RST_LOW_CYC-1:RST_LOW_CYC+1]}) else $error("bad master low length");
  device_low_len_a:
    assert property ($rose(deviceLineOe_n) |-> st_q.dLow inside
      {[PRES_CYC-1:PRES_CYC+1], [HOLD_CYC-1:HOLD_CYC+1]}) else $error("bad device low length");
  idle_low_a:
    assert property (st_q.mLow <= RST_LOW_CYC) else $error("master held wire low too long");
  reset_gap_a:
    assert property ($fell(masterLineOe_n) && st_q.lastRst |-> st_q.mHigh >= RST_HIGH_CYC - 2)
      else $error("slot started inside reset high time");
  slot_gap_a:
    assert property ($fell(masterLineOe_n) && !st_q.lastRst
      |-> st_q.mHigh >= SLOT_LEN_CYC - W0_CYC - 2) else $error("recovery too short");
  presence_due_a:
    assert property ($rose(masterLineOe_n) && st_q.mLow inside {[RST_LOW_CYC-1:RST_LOW_CYC+1]}
      |-> ##[PRES_LO:PRES_HI] !deviceLineOe_n) else $error("presence pulse missing");
  reset_seen_c: cover property ($rose(masterLineOe_n) && st_q.lastRst == 1'b0 &&
    st_q.mLow inside {[RST_LOW_CYC-1:RST_LOW_CYC+1]});
  presence_seen_c: cover property ($rose(deviceLineOe_n) && st_q.dLow inside
    {[PRES_CYC-1:PRES_CYC+1]});
  read_zero_c: cover property ($rose(deviceLineOe_n) && st_q.dLow inside
    {[HOLD_CYC-1:HOLD_CYC+1]});
endmodule

/* File: single_wire_slave_slot_signaling_tb.sv */
// self-checking bench: master and device ends joined on one wire
// assumes shortened reset and presence counts as set below
`timescale 1ns/100ps
module single_wire_slave_slot_signaling_tb;
  import swire_pkg::*;
  localparam int RL = 7000;
  localparam int RH = 600;
  localparam int SL = 7000;
  // write-zero outlasts the device sample point, reset outlasts write-zero
  localparam int W0 = 6400;
  localparam int PS = 70;
  localparam int RD = 6600;
  localparam logic [CMD_BITS-1:0] CMD_WORD = 8'ha5;
  logic                sys_clk  = 1'b0;
  logic                reset_n  = 1'b0;
  logic                reqValid = 1'b0;
  cmd_t                reqCmd   = CMD_RESET;
  logic                reqBit   = 1'b0;
  logic                txBit    = 1'b0;
  logic                readMode = 1'b0;
  logic                lastRx   = 1'b0;
  logic                reqReady, doneValid, doneBit;
  logic                rxValid, rxBit, txTaken, cmdValid, linkReady, busReset;
  logic [CMD_BITS-1:0] cmdByte;
  int                  rxCount = 0, takeCount = 0, rstCount = 0, cmdCount = 0, rxBase = 0;
  int                  bad_count = 0, num_checks = 0;
  swire_if bus ();
  swire_master #(.RST_LOW_CYC(RL), .RST_HIGH_CYC(RH), .SLOT_LEN_CYC(SL), .PRES_SMP_CYC(PS),
    .W0_LOW_CYC(W0)) i_swire_master (
    .sys_clk(sys_clk), .reset_n(reset_n), .bus(bus), .reqValid(reqValid), .reqCmd(reqCmd),
    .reqBit(reqBit), .reqReady(reqReady), .doneValid(doneValid), .doneBit(doneBit));
  swire_device #(.WAIT_CYC(20), .PRES_CYC(60), .RST_CYC(RD)) i_swire_device (
    .sys_clk(sys_clk), .reset_n(reset_n), .bus(bus), .txBit(txBit), .readMode(readMode),
    .rxValid(rxValid), .rxBit(rxBit), .txTaken(txTaken), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .linkReady(linkReady), .busReset(busReset));
  swire_chk #(.RST_LOW_CYC(RL), .RST_HIGH_CYC(RH), .SLOT_LEN_CYC(SL), .WAIT_CYC(20),
    .PRES_CYC(60), .W0_CYC(W0)) i_swire_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .masterLineOut(bus.masterLineOut),
    .masterLineOe_n(bus.masterLineOe_n), .deviceLineOut(bus.deviceLineOut),
    .deviceLineOe_n(bus.deviceLineOe_n), .line(bus.line));
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // device-side pulse capture
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (rxValid === 1'b1)
    begin
      lastRx <= rxBit;
      rxCount++;
    end
    if (txTaken === 1'b1)
      takeCount++;
    if (busReset === 1'b1)
      rstCount++;
    if (cmdValid === 1'b1)
      cmdCount++;
  end
  // ----------------------------------------
  // compare, request and report tasks
  // ----------------------------------------
  task automatic check1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic request(input cmd_t cmd, input logic b);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (reqReady !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 100)
    begin
      check1(reqReady, 1'b1);
      final_report();
    end
    reqCmd = cmd;
    reqBit = b;
    reqValid = 1'b1;
    @(negedge sys_clk);
    reqValid = 1'b0;
    while (doneValid !== 1'b1 && n < 20000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 20000)
    begin
      check1(doneValid, 1'b1);
      final_report();
    end
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    request(CMD_RESET, 1'b0);
    check1(doneBit, 1'b1);
    check8(8'(rstCount), 8'h01);
    check1(linkReady, 1'b1);
    check1(reqReady, 1'b1);
    // the reset low also reads as a zero slot until it is recognised
    rxBase = rxCount;
    $display("test reset and presence ended");
    for (int i = 0; i < CMD_BITS; i++)
    begin
      request(CMD_WRITE, CMD_WORD[i]);
      check1(lastRx, CMD_WORD[i]);
    end
    check8(8'(rxCount - rxBase), 8'h08);
    check8(cmdByte, CMD_WORD);
    check8(8'(cmdCount), 8'h01);
    $display("test command byte ended");
    readMode = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      txBit = i[0];
      request(CMD_READ, 1'b0);
      check1(doneBit, i[0]);
    end
    check8(8'(takeCount), 8'h02);
    $display("test read slots ended");
    readMode = 1'b0;
    request(CMD_RESET, 1'b0);
    check1(doneBit, 1'b1);
    check8(8'(rstCount), 8'h02);
    check1(linkReady, 1'b1);
    $display("test second reset ended");
    final_report();
  end
endmodule
